// ---- core/gpoc_pkg.sv ----
package gpoc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONFIG = 8'h4d;
  localparam logic [7:0] IDX_LEVELS = 8'h4e;
  localparam logic [7:0] IDX_PWM0_LOW = 8'h4f;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;

  localparam int NUM_PINS = 5;
  localparam int DATA_W = 16;
  localparam int BUS_W = 32;

  // reset values
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] LEVELS_RESET = 16'h0000;
  localparam logic [15:0] PWM0_LOW_RESET = 16'h007f;

  // writable bits of the config register: bit 15 and bit 1 are reserved
  localparam logic [15:0] CONFIG_WMASK = 16'h7ffd;

  // pin numbers carrying an internal function
  localparam int PIN_MHD = 0;
  localparam int PIN_FAULT = 2;
  localparam int PIN_OCA = 3;
  localparam int PIN_OCB = 4;

  // pwm tick lengths in modulator clocks, minus one
  localparam logic [9:0] TICK_16_M1 = 10'h00f;
  localparam logic [9:0] TICK_64_M1 = 10'h03f;
  localparam logic [9:0] TICK_256_M1 = 10'h0ff;
  localparam logic [9:0] TICK_1024_M1 = 10'h3ff;

  localparam logic [1:0] TB_16 = 2'h0;
  localparam logic [1:0] TB_64 = 2'h1;
  localparam logic [1:0] TB_256 = 2'h2;

  localparam logic [6:0] COUNT_ONE = 7'h01;
  localparam logic [6:0] COUNT_ZERO = 7'h00;
  localparam logic [9:0] TICK_ZERO = 10'h000;
  localparam logic [9:0] TICK_ONE = 10'h001;

  // direction, source and format bits of the config register
  typedef struct packed {
    logic reserved_hi;
    logic [4:0] format;
    logic [4:0] direction;
    logic [4:0] source_select; // bit 1 reserved
  } gpoc_config_t;

  // pin-0 low-level pwm timing
  typedef struct packed {
    logic [1:0] tick_select;
    logic [6:0] high_count;
    logic [6:0] low_count;
  } gpoc_pwm_t;

  // one-hot pwm phase
  typedef enum logic [1:0] {
    PWM_HIGH = 2'b01,
    PWM_LOW = 2'b10
  } gpoc_phase_t;

endpackage

// ---- core/gpoc_top.sv ----
`timescale 1ns/1ps
// How it works
// - direction bits 9:5 for pins 4..0; 1 output, 0 input; reset 0
// - pin 4 output: select 0 gives overcurrent flag b, 1 gives gpio path
// - pin 3 output: select 0 gives overcurrent flag a, 1 gives gpio path
// - pin 2 output: select 0 gives fault, 1 gives gpio path
// - pin 0 output: select 0 gives missing host detect; pin 1 no select
// - config bit 1 reserved, ignores writes, reads zero
// - level bits 4:0 set the driven level on gpio outputs; reset 0
// - level bit ignored when pin is input or runs its function
// - level bits 15:5 plain read/write storage, reset 0, no effect
// - pin-0 pwm register: tick select 15:14, high 13:7, low 6:0
// - tick select picks 16, 64, 256 or 1024 clocks per pwm tick
// - format 0 static levels, format 1 pwm waveform from pwm_wave_ext; only pin 0 can use the timing regs
module gpoc_top (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gpoc_pkg::ADDR_W-1:0] paddr,
  input wire logic [gpoc_pkg::BUS_W-1:0] pwdata,
  output logic [gpoc_pkg::BUS_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // internal function sources, same clock
  input wire logic overcurrent_flag_a,
  input wire logic overcurrent_flag_b,
  input wire logic fault,
  input wire logic missing_host_detect,
  // waveforms from pwm engines outside this block
  input wire logic [gpoc_pkg::NUM_PINS-1:0] pwm_wave_ext,
  // pin drivers
  output logic [gpoc_pkg::NUM_PINS-1:0] pin_out,
  output logic [gpoc_pkg::NUM_PINS-1:0] pin_oe_n
);

  gpoc_pkg::gpoc_config_t config_q;
  logic [gpoc_pkg::DATA_W-1:0] levels_q;
  gpoc_pkg::gpoc_pwm_t pwm0_q;
  logic pready_q;
  logic pslverr_q;
  logic [gpoc_pkg::BUS_W-1:0] prdata_q;
  logic [gpoc_pkg::NUM_PINS-1:0] pin_out_q;
  logic [gpoc_pkg::NUM_PINS-1:0] pin_oe_n_q;

  logic [7:0] index;
  logic hit_config;
  logic hit_levels;
  logic hit_pwm0;
  logic mapped;
  logic access;
  logic do_write;
  logic [gpoc_pkg::DATA_W-1:0] rd_d;

  // word index from the byte address
  assign index = paddr[gpoc_pkg::IDX_LSB +: 8];
  assign access = psel && penable;
  // a write lands on the edge where pready is seen high
  assign do_write = access && pready_q && pwrite && !pslverr_q;

  // address decode
  always_comb begin
    hit_config = 1'b0;
    hit_levels = 1'b0;
    hit_pwm0 = 1'b0;
    if (index == gpoc_pkg::IDX_CONFIG) begin
      hit_config = 1'b1;
    end else if (index == gpoc_pkg::IDX_LEVELS) begin
      hit_levels = 1'b1;
    end else if (index == gpoc_pkg::IDX_PWM0_LOW) begin
      hit_pwm0 = 1'b1;
    end
    mapped = hit_config || hit_levels || hit_pwm0;
  end

  // read mux; reserved config bits always come back zero
  always_comb begin
    rd_d = '0;
    if (hit_config) begin
      rd_d = config_q & gpoc_pkg::CONFIG_WMASK;
    end else if (hit_levels) begin
      rd_d = levels_q;
    end else if (hit_pwm0) begin
      rd_d = pwm0_q;
    end
  end

  // one wait state: answer in the second access cycle, keeps decode off
  // the bus path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      if (access && !pready_q) begin
        pready_q <= 1'b1;
        pslverr_q <= !mapped;
        prdata_q <= (pwrite || !mapped) ? '0 : {16'h0000, rd_d};
      end else begin
        pready_q <= 1'b0;
        pslverr_q <= 1'b0;
        prdata_q <= '0;
      end
    end
  end

  // direction, source select and format storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_q <= gpoc_pkg::CONFIG_RESET;
    end else if (do_write && hit_config) begin
      // reserved bits never take a write
      config_q <= pwdata[15:0] & gpoc_pkg::CONFIG_WMASK;
    end
  end

  // output levels plus spare bits kept only for map checking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      levels_q <= gpoc_pkg::LEVELS_RESET;
    end else if (do_write && hit_levels) begin
      levels_q <= pwdata[15:0];
    end
  end

  // pin-0 pwm timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm0_q <= gpoc_pkg::PWM0_LOW_RESET;
    end else if (do_write && hit_pwm0) begin
      pwm0_q <= pwdata[15:0];
    end
  end

  // pwm tick prescaler
  logic [9:0] tick_cnt_q;
  logic [9:0] tick_last;
  logic tick;
  logic pwm0_on;

  always_comb begin
    if (pwm0_q.tick_select == gpoc_pkg::TB_16) begin
      tick_last = gpoc_pkg::TICK_16_M1;
    end else if (pwm0_q.tick_select == gpoc_pkg::TB_64) begin
      tick_last = gpoc_pkg::TICK_64_M1;
    end else if (pwm0_q.tick_select == gpoc_pkg::TB_256) begin
      tick_last = gpoc_pkg::TICK_256_M1;
    end else begin
      tick_last = gpoc_pkg::TICK_1024_M1;
    end
  end

  assign pwm0_on = config_q.format[gpoc_pkg::PIN_MHD];
  assign tick = (tick_cnt_q >= tick_last);

  // prescaler restarts while pwm is off so the first period is whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= gpoc_pkg::TICK_ZERO;
    end else if (!pwm0_on || tick) begin
      tick_cnt_q <= gpoc_pkg::TICK_ZERO;
    end else begin
      tick_cnt_q <= tick_cnt_q + gpoc_pkg::TICK_ONE;
    end
  end

  // pwm phase machine: high for high_count ticks, then low_count ticks
  gpoc_pkg::gpoc_phase_t phase_q;
  logic [6:0] phase_cnt_q;
  logic [6:0] phase_next;
  logic pwm0_wave;

  assign phase_next = phase_cnt_q + gpoc_pkg::COUNT_ONE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= gpoc_pkg::PWM_HIGH;
      phase_cnt_q <= gpoc_pkg::COUNT_ZERO;
    end else if (!pwm0_on) begin
      phase_q <= gpoc_pkg::PWM_HIGH;
      phase_cnt_q <= gpoc_pkg::COUNT_ZERO;
    end else begin
      case (phase_q)
        gpoc_pkg::PWM_HIGH: begin
          // a zero count skips the phase at once
          if (pwm0_q.high_count == gpoc_pkg::COUNT_ZERO) begin
            phase_q <= gpoc_pkg::PWM_LOW;
            phase_cnt_q <= gpoc_pkg::COUNT_ZERO;
          end else if (tick) begin
            if (phase_next >= pwm0_q.high_count) begin
              phase_q <= gpoc_pkg::PWM_LOW;
              phase_cnt_q <= gpoc_pkg::COUNT_ZERO;
            end else begin
              phase_cnt_q <= phase_next;
            end
          end
        end
        gpoc_pkg::PWM_LOW: begin
          if (pwm0_q.low_count == gpoc_pkg::COUNT_ZERO) begin
            phase_q <= gpoc_pkg::PWM_HIGH;
            phase_cnt_q <= gpoc_pkg::COUNT_ZERO;
          end else if (tick) begin
            if (phase_next >= pwm0_q.low_count) begin
              phase_q <= gpoc_pkg::PWM_HIGH;
              phase_cnt_q <= gpoc_pkg::COUNT_ZERO;
            end else begin
              phase_cnt_q <= phase_next;
            end
          end
        end
        default: begin
          phase_q <= gpoc_pkg::PWM_HIGH;
          phase_cnt_q <= gpoc_pkg::COUNT_ZERO;
        end
      endcase
    end
  end

  // local waveform; a zero low count keeps the level high for good, since
  // the phase machine still passes one clock through the skipped phase
  logic pwm0_local;
  assign pwm0_local = (pwm0_q.high_count != gpoc_pkg::COUNT_ZERO) &&
    ((phase_q == gpoc_pkg::PWM_HIGH) ||
    (pwm0_q.low_count == gpoc_pkg::COUNT_ZERO));

  // level-low code uses the local timing; level-high code comes from outside
  assign pwm0_wave = levels_q[gpoc_pkg::PIN_MHD] ?
    pwm_wave_ext[gpoc_pkg::PIN_MHD] : pwm0_local;

  // gpio path per pin: static level or pwm waveform
  logic [gpoc_pkg::NUM_PINS-1:0] gpio_path;
  logic [gpoc_pkg::NUM_PINS-1:0] func_src;
  logic [gpoc_pkg::NUM_PINS-1:0] use_func;
  logic [gpoc_pkg::NUM_PINS-1:0] drive_d;

  always_comb begin
    gpio_path = levels_q[gpoc_pkg::NUM_PINS-1:0];
    for (int i = 0; i < gpoc_pkg::NUM_PINS; i++) begin
      if (config_q.format[i]) begin
        gpio_path[i] = pwm_wave_ext[i];
      end
    end
    if (config_q.format[gpoc_pkg::PIN_MHD]) begin
      gpio_path[gpoc_pkg::PIN_MHD] = pwm0_wave;
    end
  end

  // internal functions; pin 1 has none
  always_comb begin
    func_src = '0;
    func_src[gpoc_pkg::PIN_OCB] = overcurrent_flag_b;
    func_src[gpoc_pkg::PIN_OCA] = overcurrent_flag_a;
    func_src[gpoc_pkg::PIN_FAULT] = fault;
    func_src[gpoc_pkg::PIN_MHD] = missing_host_detect;
    // select 0 picks the function; bit 1 is held zero but pin 1 ignores it
    use_func = ~config_q.source_select;
    use_func[1] = 1'b0;
    for (int i = 0; i < gpoc_pkg::NUM_PINS; i++) begin
      // level bit reaches the pin only on the gpio path
      drive_d[i] = use_func[i] ? func_src[i] : gpio_path[i];
    end
  end

  // registered pin drivers; value parked low while the pin is an input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_q <= '0;
      pin_oe_n_q <= '1;
    end else begin
      pin_oe_n_q <= ~config_q.direction;
      pin_out_q <= drive_d & config_q.direction;
    end
  end

  assign pin_out = pin_out_q;
  assign pin_oe_n = pin_oe_n_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule

// ---- verif/gpoc_assertions.sv ----
`timescale 1ns/1ps
// watches apb answers and pin drivers against a shadow of the registers
module gpoc_checker (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // functions and pins
  input wire logic overcurrent_flag_a,
  input wire logic overcurrent_flag_b,
  input wire logic fault,
  input wire logic missing_host_detect,
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe_n
);
  logic [15:0] cfg_q;
  logic [15:0] lvl_q;
  logic wr_ok;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  // shadow copies, so pin checks need no readback
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= 16'h0000;
      lvl_q <= 16'h0000;
    end else if (wr_ok && paddr[9:2] == gpoc_pkg::IDX_CONFIG) begin
      cfg_q <= pwdata[15:0] & gpoc_pkg::CONFIG_WMASK;
    end else if (wr_ok && paddr[9:2] == gpoc_pkg::IDX_LEVELS) begin
      lvl_q <= pwdata[15:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_dir_enable: assert property (pin_oe_n == ~$past(cfg_q[9:5]))
    else $error("output enable does not follow direction");
  a_input_quiet: assert property ((pin_out & pin_oe_n) == 5'h00)
    else $error("pin driven high while input");
  a_ocb_route: assert property ($past(cfg_q[9] && !cfg_q[4])
    |-> pin_out[4] == $past(overcurrent_flag_b)) else $error("pin 4 route");
  a_oca_route: assert property ($past(cfg_q[8] && !cfg_q[3])
    |-> pin_out[3] == $past(overcurrent_flag_a)) else $error("pin 3 route");
  a_fault_route: assert property ($past(cfg_q[7] && !cfg_q[2])
    |-> pin_out[2] == $past(fault)) else $error("pin 2 route");
  a_host_route: assert property ($past(cfg_q[5] && !cfg_q[0])
    |-> pin_out[0] == $past(missing_host_detect)) else $error("pin 0 route");
  a_level_drive: assert property ($past(cfg_q[6] && !cfg_q[11])
    |-> pin_out[1] == $past(lvl_q[1])) else $error("pin 1 level");
  a_rsv_zero: assert property (pready && !pwrite
    && paddr[9:2] == gpoc_pkg::IDX_CONFIG |-> !prdata[15] && !prdata[1])
    else $error("reserved config bit reads one");
endmodule

bind gpoc_top gpoc_checker i_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .overcurrent_flag_a,
  .overcurrent_flag_b, .fault, .missing_host_detect, .pin_out, .pin_oe_n);

// ---- verif/gpoc_host.sv ----
`timescale 1ns/1ps
// host side: plain apb master, one transfer at a time
module gpoc_host (
  // clock
  input wire logic pclk,
  // request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // answer
  input wire logic pready
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // holds the request until pready is seen at a rising edge, giving up after 20 edges
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic ok);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    ok = 1'b0;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge pclk);
      ok = pready;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines must not look like stale valid data
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ---- verif/gpoc_top_tb.sv ----
`timescale 1ns/1ps
// self-checking bench for the pin configuration block
module gpoc_top_tb;
  typedef struct packed {
    logic rd;
    logic err;
    logic [31:0] val;
  } gpoc_note_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [31:0] seed = 32'h00016521;
  logic [3:0] fn_q = 4'h0;
  logic [3:0] fn_prev = 4'h0;
  logic [4:0] wave_q = 5'h00;
  logic [4:0] wave_prev = 5'h00;
  logic [4:0] pin_out, pin_oe_n;
  logic [15:0] cfgs [4] = '{16'h03e0, 16'h03fd, 16'h0000, 16'h03e2};
  int mismatches = 0;
  int check_count = 0;
  gpoc_note_t notes[$];
  gpoc_note_t nt;
  always #5 pclk = ~pclk;
  gpoc_host i_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready);
  gpoc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .overcurrent_flag_a(fn_q[2]),
    .overcurrent_flag_b(fn_q[3]), .fault(fn_q[1]),
    .missing_host_detect(fn_q[0]), .pwm_wave_ext(wave_q), .pin_out,
    .pin_oe_n);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // function inputs wander every cycle; the last value is kept
  always @(posedge pclk) begin
    seed <= lfsr(seed);
    fn_q <= seed[3:0];
    wave_q <= seed[8:4];
    fn_prev <= fn_q;
    wave_prev <= wave_q;
  end
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one access; its expected answer is queued for the monitor
  task automatic acc(input logic w, input logic [7:0] idx,
      input logic [31:0] d, input logic [31:0] exp, input logic err);
    notes.push_back('{!w, err, exp});
    i_host.xfer(w, {2'h0, idx, 2'h0}, d, ok);
    if (!ok) begin
      check("timeout", 32'h0, 32'h1);
      close_out();
    end
  endtask
  // pins settle one edge after the inputs they follow
  task automatic pins(input logic [15:0] cfg, input logic [4:0] lvl);
    logic [4:0] sel;
    logic [4:0] fn;
    logic [4:0] exp;
    @(negedge pclk);
    sel = cfg[4:0] | 5'h02;
    fn = {fn_prev[3:1], 1'b0, fn_prev[0]};
    exp = cfg[9:5] & ((~sel & fn) | (sel & lvl));
    check("pin_out", {27'h0, pin_out}, {27'h0, exp});
    check("pin_oe_n", {27'h0, pin_oe_n}, {27'h0, ~cfg[9:5]});
  endtask
  // waits at falling edges while pin 0 holds lvl; n counts the clocks
  task automatic wait_pin0(input logic lvl, output int n);
    n = 0;
    while (n < 4000 && pin_out[0] === lvl) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 4000) begin
      check("pin 0 timeout", 32'h0, 32'h1);
      close_out();
    end
  endtask
  // pin 0 local pwm: one whole high run and one low run, in clocks
  task automatic pwm_run(input logic [1:0] tsel, input logic [6:0] hc,
      input logic [6:0] lc);
    int n;
    int tk;
    tk = 16 << (2 * tsel);
    acc(1'b1, gpoc_pkg::IDX_LEVELS, 32'h0, 32'h0, 1'b0);
    acc(1'b1, gpoc_pkg::IDX_CONFIG, 32'h0021, 32'h0, 1'b0);
    acc(1'b1, gpoc_pkg::IDX_PWM0_LOW, {16'h0, tsel, hc, lc}, 32'h0, 1'b0);
    acc(1'b1, gpoc_pkg::IDX_CONFIG, 32'h0421, 32'h0, 1'b0);
    wait_pin0(1'b0, n);
    wait_pin0(1'b1, n);
    check("pwm high clocks", n, tk * hc);
    wait_pin0(1'b0, n);
    check("pwm low clocks", n, tk * lc);
  endtask
  // takes the oldest note whenever an answer appears
  always @(posedge pclk) begin
    if (presetn && psel && penable && pready) begin
      nt = notes.pop_front();
      check("pslverr", {31'h0, pslverr}, {31'h0, nt.err});
      if (nt.rd) check("prdata", prdata, nt.val);
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    acc(1'b0, gpoc_pkg::IDX_CONFIG, 32'h0, 32'h0, 1'b0);
    acc(1'b0, gpoc_pkg::IDX_LEVELS, 32'h0, 32'h0, 1'b0);
    acc(1'b0, gpoc_pkg::IDX_PWM0_LOW, 32'h0, 32'h7f, 1'b0);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      r = seed;
      acc(1'b1, gpoc_pkg::IDX_CONFIG, r, 32'h0, 1'b0);
      acc(1'b0, gpoc_pkg::IDX_CONFIG, 32'h0, r & 32'h7ffd, 1'b0);
      acc(1'b1, gpoc_pkg::IDX_LEVELS, r, 32'h0, 1'b0);
      acc(1'b0, gpoc_pkg::IDX_LEVELS, 32'h0, r & 32'hffff, 1'b0);
      acc(1'b1, gpoc_pkg::IDX_PWM0_LOW, ~r, 32'h0, 1'b0);
      acc(1'b0, gpoc_pkg::IDX_PWM0_LOW, 32'h0, ~r & 32'hffff, 1'b0);
      acc(1'b1, 8'h50, r, 32'h0, 1'b1);
      acc(1'b0, 8'h50, 32'h0, 32'h0, 1'b1);
    end
    $display("test register readback done");
    r = seed;
    acc(1'b1, gpoc_pkg::IDX_LEVELS, r, 32'h0, 1'b0);
    foreach (cfgs[k]) begin
      acc(1'b1, gpoc_pkg::IDX_CONFIG, {16'h0, cfgs[k]}, 32'h0, 1'b0);
      repeat (2) @(posedge pclk);
      repeat (6) pins(cfgs[k], r[4:0]);
    end
    $display("test pin routing done");
    acc(1'b1, gpoc_pkg::IDX_LEVELS, 32'h0001, 32'h0, 1'b0);
    acc(1'b1, gpoc_pkg::IDX_CONFIG, 32'h7ffd, 32'h0, 1'b0);
    repeat (2) @(posedge pclk);
    repeat (6) begin
      @(negedge pclk);
      check("pin_out wave", {27'h0, pin_out}, {27'h0, wave_prev});
    end
    pwm_run(2'h0, 7'h02, 7'h03);
    pwm_run(2'h3, 7'h01, 7'h02);
    $display("test pwm format done");
    close_out();
  end
endmodule
